// file: src/hzm_regs.svh
`ifndef HZM_REGS_SVH
`define HZM_REGS_SVH
`define HZM_CTRL 8'h00
`define HZM_ZM_VEL 8'h04
`define HZM_RP_VEL 8'h08
`define HZM_MAX_ZM_DIST 8'h0C
`define HZM_ZM_TOL 8'h10
`define HZM_RP_OFFSET 8'h14
`define HZM_REF_COORD 8'h18
`define HZM_INNER_WIN 8'h1C
`define HZM_OUTER_WIN 8'h20
`define HZM_STATUS 8'h24
`define HZM_CAM_TO_MARK 8'h28
`define HZM_PROBE_VALUE 8'h2C
`define HZM_NUM_CFG 4'h9
`define HZM_CTRL_CAM 0
`define HZM_CTRL_DIR 1
`define HZM_CTRL_INV 2
`define HZM_CTRL_SEL_LO 3
`define HZM_CTRL_PSEL 5
`define HZM_CTRL_PEDGE 6
`define HZM_CTRL_PATH 7
`define HZM_ST_SEARCH 0
`define HZM_ST_FLY 1
`define HZM_ST_VALID 2
`define HZM_ST_OUTWIN 3
`define HZM_ST_NOTFOUND 4
`define HZM_ST_HOMED 11
`define HZM_REG_RST 32'h0000_0000
`endif

// file: src/hzm_pkg.sv
package hzm_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SEARCH, ST_TRAVEL, ST_BRAKE, ST_RETURN, ST_FLY
    } hzm_state_t;
    typedef struct packed {
        logic move;
        logic dir;
        logic [31:0] vel;
    } hzm_motion_t;
    typedef struct packed {
        logic load_act;
        logic load_set;
        logic corr;
        logic path_corr;
        logic signed [31:0] value;
    } hzm_pos_cmd_t;
endpackage : hzm_pkg

// file: src/hzm_homing.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
`include "hzm_regs.svh"
module hzm_homing
    import hzm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // axis sensors and commands
    input wire logic start_referencing_input,
    input wire logic referencing_type_select,
    input wire logic cam_switch_input,
    input wire logic zero_mark,
    input wire logic [2:0] ext_mark,
    input wire logic [1:0] probe_in,
    input wire logic signed [31:0] pos_actual,
    input wire logic [31:0] brake_dist,
    input wire logic standstill,
    // motion and position outputs
    output hzm_motion_t motion,
    output hzm_pos_cmd_t pos_cmd,
    output logic homed_flag,
    output logic offset_out_of_window_alarm
);
    logic [31:0] regs [9];
    logic [7:0] waddr;
    logic aw_got, w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    hzm_state_t state;
    logic search_active_flag, flying_active_flag, outside_outer_window_flag;
    logic measurement_valid_bit, not_found;
    logic [31:0] cam_to_mark_distance, probe_captured_value;
    logic signed [31:0] search_start, cam_leave, target;
    logic start_q, cam_q, mark_q, probe_q;

    wire wr_go = aw_got && w_got && !s_axi_bvalid;
    wire reference_cam_present = regs[0][`HZM_CTRL_CAM];
    wire approach_start_direction = regs[0][`HZM_CTRL_DIR];
    wire mark_edge_invert = regs[0][`HZM_CTRL_INV];
    wire [1:0] equivalent_mark_input_select = regs[0][`HZM_CTRL_SEL_LO +: 2];
    wire probe_select = regs[0][`HZM_CTRL_PSEL];
    wire probe_edge_select = regs[0][`HZM_CTRL_PEDGE];
    wire offset_in_path_select = regs[0][`HZM_CTRL_PATH];
    wire [31:0] zero_mark_approach_velocity = regs[1];
    wire [31:0] ref_point_approach_velocity = regs[2];
    wire [31:0] max_zero_mark_distance = regs[3];
    wire [31:0] zero_mark_tolerance = regs[4];
    wire signed [31:0] ref_point_offset = regs[5];
    // coordinate input is tied to its setting register
    wire signed [31:0] ref_coordinate_input = regs[6];
    wire [31:0] inner_window = regs[7];
    wire [31:0] outer_window = regs[8];

    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        abs32 = v[31] ? 32'(-v) : 32'(v);
    endfunction : abs32

    wire [31:0] status = {20'h0_0000, homed_flag, 6'h00, not_found,
        outside_outer_window_flag, measurement_valid_bit, flying_active_flag,
        search_active_flag};

    // axi write: address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            waddr <= 8'h00;
            wdata <= 32'h0000_0000;
            wstrb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_got <= 1'b1;
                waddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_got <= 1'b1;
                wdata <= s_axi_wdata;
                wstrb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (waddr <= `HZM_STATUS && waddr[1:0] == 2'b00) ?
                    2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // configuration words, byte lanes honoured
    for (genvar i = 0; i < 9; i++) begin : g_cfg
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                regs[i] <= `HZM_REG_RST;
            end else if (wr_go && waddr == 8'(i * 4)) begin
                for (int b = 0; b < 4; b++) begin
                    if (wstrb[b]) begin
                        regs[i][b*8 +: 8] <= wdata[b*8 +: 8];
                    end
                end
            end
        end
    end

    // axi read, unmapped answers slverr with zero data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            if (s_axi_araddr[1:0] != 2'b00) begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;
            end else if (s_axi_araddr < `HZM_STATUS) begin
                s_axi_rdata <= regs[s_axi_araddr[5:2]];
            end else if (s_axi_araddr == `HZM_STATUS) begin
                s_axi_rdata <= status;
            end else if (s_axi_araddr == `HZM_CAM_TO_MARK) begin
                s_axi_rdata <= cam_to_mark_distance;
            end else if (s_axi_araddr == `HZM_PROBE_VALUE) begin
                s_axi_rdata <= probe_captured_value;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // edge detection on synchronous inputs
    wire ext_sel = equivalent_mark_input_select != 2'b00;
    wire mark_now = ext_sel ? ext_mark[2'(equivalent_mark_input_select - 2'b01)]
        : zero_mark;
    wire want_rise = !motion.dir ^ (ext_sel && mark_edge_invert);
    wire mark_edge = want_rise ? (mark_now && !mark_q) : (!mark_now && mark_q);
    wire probe_now = probe_in[probe_select];
    wire probe_edge = probe_edge_select ? (!probe_now && probe_q)
        : (probe_now && !probe_q);
    wire start_rise = start_referencing_input && !start_q;
    wire go_search = state == ST_IDLE && start_rise && !referencing_type_select;
    wire go_fly = state == ST_IDLE && start_rise && referencing_type_select;
    wire abort = state != ST_IDLE && !start_referencing_input;
    wire [31:0] travelled = abs32(32'(pos_actual - search_start));
    wire band_ok = !cam_switch_input &&
        travelled <= 32'(max_zero_mark_distance - zero_mark_tolerance);
    wire lost = state == ST_SEARCH && travelled > max_zero_mark_distance;
    wire mark_hit = state == ST_SEARCH && search_active_flag && mark_edge && !abort;
    wire signed [31:0] step_off = motion.dir ? 32'(-ref_point_offset) : ref_point_offset;
    wire need_back = ref_point_offset[31] ||
        brake_dist > abs32(ref_point_offset);
    wire passed = motion.dir ? (pos_actual <= target) : (pos_actual >= target);
    wire arrive = (state == ST_TRAVEL || state == ST_RETURN) && passed && !abort;
    wire capture = state == ST_FLY && flying_active_flag && probe_edge && !abort;
    wire signed [31:0] diff = 32'(ref_coordinate_input - pos_actual);
    wire [31:0] adiff = abs32(diff);
    // inclusive bounds; relies on outer above inner being kept by software
    wire in_band = adiff >= inner_window && adiff <= outer_window;
    wire above = adiff > outer_window;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            cam_q <= 1'b0;
            mark_q <= 1'b0;
            probe_q <= 1'b0;
        end else begin
            start_q <= start_referencing_input;
            cam_q <= cam_switch_input;
            mark_q <= mark_now;
            probe_q <= probe_now;
        end
    end

    // sequencer; override input is deliberately absent, speeds are absolute
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            motion <= '0;
            search_start <= 32'sh0000_0000;
            cam_leave <= 32'sh0000_0000;
            target <= 32'sh0000_0000;
            cam_to_mark_distance <= 32'h0000_0000;
        end else if (abort || lost) begin
            state <= ST_IDLE;
            motion <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go_search) begin
                        state <= ST_SEARCH;
                        search_start <= pos_actual;
                        cam_leave <= pos_actual;
                        motion.move <= 1'b1;
                        motion.vel <= zero_mark_approach_velocity;
                        motion.dir <= reference_cam_present ?
                            !approach_start_direction :
                            approach_start_direction;
                    end else if (go_fly) begin
                        state <= ST_FLY;
                    end
                end
                ST_SEARCH: begin
                    if (cam_q && !cam_switch_input) begin
                        cam_leave <= pos_actual;
                    end
                    if (mark_hit) begin
                        cam_to_mark_distance <= abs32(32'(pos_actual - cam_leave));
                        target <= 32'(pos_actual + step_off);
                        if (need_back) begin
                            state <= ST_BRAKE;
                            motion.move <= 1'b0;
                            motion.vel <= 32'h0000_0000;
                        end else begin
                            state <= ST_TRAVEL;
                            if (!(ext_sel && !reference_cam_present)) begin
                                motion.vel <= ref_point_approach_velocity;
                            end // external mark without reference cam keeps its speed
                        end
                    end
                end
                ST_BRAKE: begin
                    if (standstill) begin
                        state <= ST_RETURN;
                        motion.move <= 1'b1;
                        motion.vel <= ref_point_approach_velocity;
                        motion.dir <= target < pos_actual;
                    end
                end
                ST_TRAVEL, ST_RETURN: begin
                    if (arrive) begin
                        state <= ST_IDLE;
                        motion <= '0;
                    end
                end
                ST_FLY: begin
                    state <= ST_FLY;
                end
                default: begin
                    state <= ST_IDLE;
                    motion <= '0;
                end
            endcase
        end
    end

    // position loads and corrections, one-cycle pulses
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_cmd <= '0;
        end else begin
            pos_cmd <= '0;
            if (arrive) begin
                pos_cmd.load_act <= 1'b1;
                pos_cmd.load_set <= 1'b1;
                pos_cmd.value <= ref_coordinate_input;
            end else if (capture && (!homed_flag || in_band)) begin
                pos_cmd.corr <= 1'b1;
                pos_cmd.path_corr <= offset_in_path_select;
                pos_cmd.value <= diff;
            end
        end
    end

    // status flags; hardware set wins over software clear
    wire clr_out = wr_go && waddr == `HZM_STATUS && wstrb[0] && wdata[`HZM_ST_OUTWIN];
    wire clr_nf = wr_go && waddr == `HZM_STATUS && wstrb[0] && wdata[`HZM_ST_NOTFOUND];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            homed_flag <= 1'b0;
            search_active_flag <= 1'b0;
            flying_active_flag <= 1'b0;
            measurement_valid_bit <= 1'b0;
            outside_outer_window_flag <= 1'b0;
            offset_out_of_window_alarm <= 1'b0;
            not_found <= 1'b0;
            probe_captured_value <= 32'h0000_0000;
        end else begin
            if (go_search) begin
                homed_flag <= 1'b0;
            end else if (arrive || capture) begin
                homed_flag <= 1'b1;
            end
            search_active_flag <= state == ST_SEARCH && !abort && band_ok;
            flying_active_flag <= (go_fly || state == ST_FLY) && !abort;
            if (go_fly) begin
                measurement_valid_bit <= 1'b0;
            end else if (capture) begin
                probe_captured_value <= pos_actual;
                measurement_valid_bit <= 1'b1;
            end
            if (capture && homed_flag && above) begin
                outside_outer_window_flag <= 1'b1;
                offset_out_of_window_alarm <= 1'b1;
            end else if (clr_out) begin
                outside_outer_window_flag <= 1'b0;
                offset_out_of_window_alarm <= 1'b0;
            end
            if (lost) begin
                not_found <= 1'b1;
            end else if (clr_nf) begin
                not_found <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_search_go;
        go_search && !abort;
    endsequence
    sequence s_fly_hit;
        capture && homed_flag;
    endsequence

    chk_cam_dir: assert property (s_search_go ##0 reference_cam_present |=>
        motion.move && motion.dir == !approach_start_direction)
        else $error("cam search direction wrong");
    chk_nocam_dir: assert property (s_search_go ##0 !reference_cam_present |=>
        state == ST_SEARCH && motion.dir == approach_start_direction)
        else $error("no-cam search direction wrong");
    chk_homed_clear: assert property (s_search_go |=> !homed_flag)
        else $error("homed not cleared at search start");
    chk_ref_load: assert property (arrive |=> pos_cmd.load_act && pos_cmd.load_set
        && pos_cmd.value == $past(ref_coordinate_input) && homed_flag)
        else $error("reference point load missing");
    chk_abort_idle: assert property (abort |=> state == ST_IDLE && !motion.move
        && !search_active_flag)
        else $error("abort did not stop search");
    chk_outer_alarm: assert property (s_fly_hit ##0 above |=>
        outside_outer_window_flag && offset_out_of_window_alarm && !pos_cmd.corr)
        else $error("outer window alarm wrong");
    chk_inner_keep: assert property (s_fly_hit ##0 adiff < inner_window |=>
        !pos_cmd.corr && !pos_cmd.load_act)
        else $error("position changed inside inner window");
    chk_band_corr: assert property (s_fly_hit ##0 in_band |=> pos_cmd.corr &&
        pos_cmd.value == $past(diff) && pos_cmd.path_corr == $past(offset_in_path_select))
        else $error("band correction wrong");
    chk_fly_homed: assert property (go_fly && homed_flag |=> homed_flag [*2])
        else $error("homed dropped at flying start");
    chk_brake_back: assert property (mark_hit && need_back |=>
        state == ST_BRAKE && !motion.move)
        else $error("brake before return missing");
endmodule : hzm_homing

// file: tb/hzm_axis_model.sv
`timescale 1ns/10ps
module hzm_axis_model
    import hzm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // commands from the homing block
    input wire hzm_motion_t motion,
    input wire hzm_pos_cmd_t pos_cmd,
    // bench hooks
    input wire logic preset,
    input wire logic signed [31:0] preset_val,
    input wire logic signed [31:0] mark_pos,
    input wire logic [31:0] brake_dist,
    // sensors
    output logic signed [31:0] pos_actual,
    output logic zero_mark,
    output logic standstill
);
    // mark is a short band so both edges show in either direction
    assign zero_mark = (pos_actual >= mark_pos) && (pos_actual < mark_pos + 32'sh10);
    // crude drive: runs out brake_dist after the move drops, so a stop overshoots
    logic [31:0] coast;
    logic coast_dir;
    logic [31:0] coast_vel;
    wire [31:0] step = (coast_vel == 32'h0000_0000 || coast < coast_vel) ? coast : coast_vel;
    assign standstill = !motion.move && coast == 32'h0000_0000;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_actual <= '0;
            coast <= '0;
            coast_dir <= 1'b0;
            coast_vel <= '0;
        end else if (preset) begin
            pos_actual <= preset_val;
            coast <= '0;
        end else if (pos_cmd.load_act) begin
            pos_actual <= pos_cmd.value;
            coast <= '0;
        end else if (pos_cmd.corr) begin
            pos_actual <= pos_actual + pos_cmd.value;
        end else if (motion.move) begin
            pos_actual <= motion.dir ? pos_actual - $signed(motion.vel)
                                     : pos_actual + $signed(motion.vel);
            coast <= brake_dist;
            coast_dir <= motion.dir;
            coast_vel <= motion.vel;
        end else if (coast != 32'h0000_0000) begin
            pos_actual <= coast_dir ? pos_actual - $signed(step) : pos_actual + $signed(step);
            coast <= coast - step;
        end
    end
endmodule : hzm_axis_model

// file: tb/tb_top.sv
`timescale 1ns/10ps
`include "hzm_regs.svh"
module tb_top
    import hzm_pkg::*;
;
    logic clk = 0, rst_n = 0, start = 0, ftype = 0, cam = 0, preset = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd, brake = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, zmark, still, homed, alarm;
    logic [1:0] bresp, rresp, rs, probe = 0;
    logic [2:0] ext = 0;
    logic signed [31:0] pos, preset_val = 0, mark_pos = 32'sh0C8;
    hzm_motion_t motion;
    hzm_pos_cmd_t pos_cmd;
    int failures = 0, compares = 0;

    hzm_homing u_hzm_homing (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .start_referencing_input(start),
        .referencing_type_select(ftype), .cam_switch_input(cam), .zero_mark(zmark),
        .ext_mark(ext), .probe_in(probe), .pos_actual(pos), .brake_dist(brake),
        .standstill(still), .motion(motion), .pos_cmd(pos_cmd), .homed_flag(homed),
        .offset_out_of_window_alarm(alarm));
    hzm_axis_model u_hzm_axis_model (.clk(clk), .rst_n(rst_n), .motion(motion),
        .pos_cmd(pos_cmd), .preset(preset), .preset_val(preset_val),
        .mark_pos(mark_pos), .brake_dist(brake), .pos_actual(pos), .zero_mark(zmark),
        .standstill(still));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task test_done;
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'h0, 32'(bresp));
    endtask : axi_wr

    task axi_rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task st(input int b, input logic e, input string nm);
        axi_rd(`HZM_STATUS);
        chk(nm, 32'(e), 32'(rd[b]));
    endtask : st

    task wait_mv(input logic e, input int lim);
        int n;
        n = 0;
        while (motion.move !== e && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk("move", 32'(e), 32'(motion.move));
    endtask : wait_mv

    task wait_load(input logic exp_flip, input logic exp_rp);
        int n;
        logic saw_rp, flip, d0;
        n = 0;
        saw_rp = 1'b0;
        flip = 1'b0;
        d0 = motion.dir;
        while (pos_cmd.load_act !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
            if (motion.vel === 32'h8) saw_rp = 1'b1;
            if (motion.move && motion.dir !== d0) flip = 1'b1;
        end
        chk("rp_speed_seen", 32'(exp_rp), 32'(saw_rp));
        chk("reversal", 32'(exp_flip), 32'(flip));
        chk("load_value", 32'h1388, pos_cmd.value);
        chk("load_set", 32'h1, 32'(pos_cmd.load_set));
        chk("homed", 32'h1, 32'(homed));
    endtask : wait_load

    task t_regs;
        axi_rd(`HZM_STATUS);
        chk("status_reset", 32'h0, rd);
        axi_rd(8'h40);
        chk("unmapped_resp", 32'h2, 32'(rs));
        axi_wr(`HZM_ZM_VEL, 32'h4);
        axi_wr(`HZM_RP_VEL, 32'h8);
        axi_wr(`HZM_MAX_ZM_DIST, 32'h3E8);
        axi_wr(`HZM_ZM_TOL, 32'hA);
        axi_wr(`HZM_RP_OFFSET, 32'h64);
        axi_wr(`HZM_REF_COORD, 32'h1388);
        axi_wr(`HZM_INNER_WIN, 32'hA);
        axi_wr(`HZM_OUTER_WIN, 32'h32);
        axi_rd(`HZM_RP_VEL);
        chk("rp_speed_reg", 32'h8, rd);
    endtask : t_regs

    task t_search;
        @(posedge clk);
        start <= 1'b1;
        wait_mv(1'b1, 6);
        chk("dir", 32'h0, 32'(motion.dir));
        chk("zm_speed", 32'h4, motion.vel);
        st(0, 1'b1, "search_flag");
        wait_load(1'b0, 1'b1);
        start <= 1'b0;
    endtask : t_search

    // external mark 1, inverted: the rise is ignored, the fall locks, speed kept
    task t_ext;
        axi_wr(`HZM_CTRL, 32'hC);
        start <= 1'b1;
        wait_mv(1'b1, 6);
        repeat (4) @(posedge clk);
        ext <= 3'h1;
        repeat (40) @(posedge clk);
        ext <= 3'h0;
        wait_load(1'b0, 1'b0);
        start <= 1'b0;
    endtask : t_ext

    task t_cam;
        axi_wr(`HZM_CTRL, 32'h1);
        mark_pos <= 32'sh12C0;
        cam <= 1'b1;
        brake <= 32'hC8;
        @(posedge clk);
        start <= 1'b1;
        wait_mv(1'b1, 6);
        chk("cam_dir", 32'h1, 32'(motion.dir));
        chk("cam_speed", 32'h4, motion.vel);
        chk("homed_clear", 32'h0, 32'(homed));
        repeat (5) @(posedge clk);
        cam <= 1'b0;
        repeat (3) @(posedge clk);
        st(0, 1'b1, "search_flag_cam");
        wait_load(1'b1, 1'b1);
        start <= 1'b0;
        brake <= 32'h0;
        axi_rd(`HZM_CAM_TO_MARK);
        chk("cam_to_mark", 32'h1, 32'(rd > 32'h64 && rd < 32'hFA));
    endtask : t_cam

    task t_fail;
        axi_wr(`HZM_CTRL, 32'h0);
        axi_wr(`HZM_MAX_ZM_DIST, 32'h50);
        mark_pos <= 32'sh0010_0000;
        start <= 1'b1;
        wait_mv(1'b1, 6);
        wait_mv(1'b0, 80);
        st(4, 1'b1, "not_found");
        chk("homed_fail", 32'h0, 32'(homed));
        start <= 1'b0;
        axi_wr(`HZM_MAX_ZM_DIST, 32'h3E8);
        start <= 1'b1;
        wait_mv(1'b1, 6);
        repeat (3) @(posedge clk);
        start <= 1'b0;
        wait_mv(1'b0, 4);
        st(0, 1'b0, "search_flag_abort");
        chk("homed_abort", 32'h0, 32'(homed));
    endtask : t_fail

    task t_fly(input logic [31:0] c, input logic signed [31:0] p, input logic h0,
               input logic ec, input logic [31:0] ev, input logic ea);
        logic [1:0] idle;
        logic seen;
        logic pc;
        logic [31:0] v;
        axi_wr(`HZM_CTRL, c);
        idle = c[6] ? 2'b11 : 2'b00;
        seen = 1'b0;
        pc = 1'b0;
        v = 32'h0;
        probe <= idle;
        preset <= 1'b1;
        preset_val <= p;
        ftype <= 1'b1;
        @(posedge clk);
        preset <= 1'b0;
        start <= 1'b1;
        repeat (4) @(posedge clk);
        chk("homed_at_start", 32'(h0), 32'(homed));
        st(1, 1'b1, "fly_flag");
        probe[c[5]] <= ~idle[0];
        repeat (6) begin
            @(posedge clk);
            if (pos_cmd.corr === 1'b1) begin
                seen = 1'b1;
                v = pos_cmd.value;
                pc = pos_cmd.path_corr;
            end
        end
        chk("corr_seen", 32'(ec), 32'(seen));
        chk("corr_value", ev, v);
        chk("path_corr", 32'(ec & c[7]), 32'(pc));
        chk("homed_fly", 32'h1, 32'(homed));
        chk("alarm", 32'(ea), 32'(alarm));
        st(3, ea, "outside_flag");
        st(2, 1'b1, "meas_valid");
        axi_rd(`HZM_PROBE_VALUE);
        chk("probe_value", p, rd);
        start <= 1'b0;
        ftype <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : t_fly

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_search;
        t_ext;
        t_cam;
        t_fail;
        t_fly(32'h0, 32'sh1324, 1'b0, 1'b1, 32'h64, 1'b0);
        t_fly(32'h0, 32'sh1383, 1'b1, 1'b0, 32'h0, 1'b0);
        t_fly(32'hE0, 32'sh1372, 1'b1, 1'b1, 32'h16, 1'b0);
        t_fly(32'h0, 32'sh1338, 1'b1, 1'b0, 32'h0, 1'b1);
        axi_wr(`HZM_STATUS, 32'h18);
        st(3, 1'b0, "outside_clear");
        chk("alarm_clear", 32'h0, 32'(alarm));
        test_done;
    end

    initial begin
        #100000;
        failures++;
        test_done;
    end
endmodule : tb_top
